/* core/uhsf_pkg.sv */
// Purpose: shared constants and types for the host link message framer
// Assumes: one 50 MHz clock, byte-level link between the two ends
// Notes:   link bytes are paced at one byte time of the current bit rate
// Functional notes
// RULE_01 - host notifies once per incoming message start
// RULE_02 - host masks notify while handling a message
// RULE_03 - four classes: command, complete, data, event
// RULE_04 - host command starts with 8-byte sync
// RULE_05 - waking device holds RTS during sleep exit
// RULE_06 - device messages start with 4-byte sync
// RULE_07 - host RTS pauses device; device resumes after
// RULE_08 - device may sleep after a response
// RULE_09 - device sends framed events on its own
// RULE_10 - long sync is 12 34 43 21 bb dd ee ff
// RULE_11 - short sync is ab cd dc ba
// RULE_12 - device ignores first four long sync bytes
// RULE_13 - host filler absorbs one byte after RTS
// RULE_14 - link starts at 115200, host may raise to 3M; code has no run-time rate change, BYTE_CYC_MIN is unused
// RULE_15 - host sends only when device RTS low
// RULE_16 - sliding comparator finds sync, drops other bytes
package uhsf_pkg;
    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned BITS_PER_BYTE = 10;
    localparam int unsigned BIT_RATE     = 115_200;   // [RULE_14]
    localparam int unsigned BIT_RATE_MAX = 3_000_000; // [RULE_14]
    // least spacing of two link bytes, rounded up
    localparam int unsigned BYTE_CYC =
        (CLK_HZ * BITS_PER_BYTE + BIT_RATE - 1) / BIT_RATE;
    localparam int unsigned BYTE_CYC_MIN =
        (CLK_HZ * BITS_PER_BYTE + BIT_RATE_MAX - 1) / BIT_RATE_MAX;
    localparam int unsigned SLEEP_EXIT_NS = 100_000;
    localparam int unsigned WAKE_CYC = (SLEEP_EXIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned CNT_W = 16;
    localparam logic [63:0] LONG_SYNC  = 64'h12344321bbddeeff; // [RULE_10]
    localparam logic [31:0] SHORT_SYNC = 32'habcddcba;         // [RULE_11]
    localparam logic [31:0] LONG_TAIL  = LONG_SYNC[31:0];      // [RULE_12]
    localparam logic [3:0]  LONG_LEN   = 4'h8;
    localparam logic [2:0]  SHORT_LEN  = 3'h4;
    localparam int unsigned JIT_DEPTH  = 4;

    typedef enum logic [1:0] {
        UHSF_CMD,
        UHSF_CPL,
        UHSF_DATA,
        UHSF_EVT
    } uhsf_class_t; // [RULE_03]

    typedef enum logic [1:0] {
        UHSF_TX_IDLE,
        UHSF_TX_WAKE,
        UHSF_TX_SYNC,
        UHSF_TX_BODY
    } uhsf_tx_t;

    typedef enum logic {
        UHSF_RX_HUNT,
        UHSF_RX_MSG
    } uhsf_rx_t;

    // sliding comparator over the last three bytes plus the new one
    function automatic logic uhsf_match(input logic [23:0] hist,
                                        input logic [7:0]  b,
                                        input logic [31:0] pat);
        uhsf_match = ({hist, b} == pat); // [RULE_16]
    endfunction
endpackage

/* core/uhsf_if.sv */
// Purpose: byte-level link between device end and host end
// Assumes: both ends on the same clock
// Notes:   valid strobes are one-cycle pulses, rts lines are levels
`timescale 1ns/1ns
`default_nettype none
interface uhsf_if;
    logic [7:0] h2d_data;
    logic       h2d_valid;
    logic [7:0] d2h_data;
    logic       d2h_valid;
    logic       dev_rts;
    logic       host_rts;

    modport dev (
        input  h2d_data,
        input  h2d_valid,
        output d2h_data,
        output d2h_valid,
        output dev_rts,
        input  host_rts
    );

    modport host (
        output h2d_data,
        output h2d_valid,
        input  d2h_data,
        input  d2h_valid,
        input  dev_rts,
        output host_rts
    );
endinterface
`default_nettype wire

/* core/uhsf_dev.sv */
// Purpose: device end of the host link framer
// Assumes: host honours dev_rts before each byte it sends
// Notes:   one received byte is held; rts covers that hold and wake-up
`timescale 1ns/1ns
`default_nettype none
module uhsf_dev #(
    parameter int unsigned BYTE_CYC = uhsf_pkg::BYTE_CYC,
    parameter int unsigned WAKE_CYC = uhsf_pkg::WAKE_CYC
) (
    input  wire logic                 clock,
    input  wire logic                 srst,
    uhsf_if.dev                       link,
    input  wire logic                 tx_valid,
    input  wire logic [7:0]           tx_data,
    input  wire logic                 tx_last,
    input  wire uhsf_pkg::uhsf_class_t tx_class,
    output logic                      tx_ready,
    output logic                      tx_busy,
    output uhsf_pkg::uhsf_class_t     tx_cur_class,
    output logic [7:0]                rx_data,
    output logic                      rx_valid,
    output logic                      rx_sof,
    input  wire logic                 rx_ready,
    input  wire logic                 rx_done,
    input  wire logic                 sleep_req,
    output logic                      asleep
);
    typedef struct packed {
        uhsf_pkg::uhsf_tx_t    tx_st;
        logic [2:0]            tx_idx;
        logic [uhsf_pkg::CNT_W-1:0] tx_gap;
        logic [7:0]            out_data;
        logic                  out_valid;
        uhsf_pkg::uhsf_class_t cls;
        logic                  sleeping;
        logic [uhsf_pkg::CNT_W-1:0] wake_cnt;
        uhsf_pkg::uhsf_rx_t    rx_st;
        logic [23:0]           rx_hist;
        logic [7:0]            hold_data;
        logic                  hold_full;
        logic                  hold_sof;
        logic                  first;
    } uhsf_dev_st_t;

    localparam logic [uhsf_pkg::CNT_W-1:0] GAP_LOAD =
        uhsf_pkg::CNT_W'(BYTE_CYC - 1);
    localparam logic [uhsf_pkg::CNT_W-1:0] WAKE_LOAD =
        uhsf_pkg::CNT_W'(WAKE_CYC - 1);

    uhsf_dev_st_t st;
    uhsf_dev_st_t next_st;
    logic         can_send;
    logic         sync_hit;
    logic         wake_ask;

    // a byte may go out once the spacing elapsed and host is not pausing
    assign can_send = (st.tx_gap == '0) && !link.host_rts; // [RULE_07]
    assign sync_hit = (st.rx_st == uhsf_pkg::UHSF_RX_HUNT) && link.h2d_valid &&
                      uhsf_pkg::uhsf_match(st.rx_hist, link.h2d_data,
                                           uhsf_pkg::LONG_TAIL); // [RULE_12] [RULE_16]
    assign wake_ask = sync_hit || (tx_valid && st.tx_st == uhsf_pkg::UHSF_TX_IDLE);

    always_comb begin
        next_st = st;
        next_st.out_valid = 1'b0;
        if (st.tx_gap != '0) begin
            next_st.tx_gap = st.tx_gap - 1'b1;
        end

        // receive side: hunt for sync, then pass bytes through the hold
        if (link.h2d_valid) begin
            next_st.rx_hist = {st.rx_hist[15:0], link.h2d_data};
        end
        if (st.rx_st == uhsf_pkg::UHSF_RX_HUNT) begin
            if (sync_hit) begin
                next_st.rx_st = uhsf_pkg::UHSF_RX_MSG; // [RULE_16]
                next_st.first = 1'b1;
            end
        end else begin
            if (st.hold_full && rx_ready) begin
                next_st.hold_full = 1'b0;
            end
            // a byte over a full hold is lost unless rx_ready drains it that cycle; host filler covers that case
            if (link.h2d_valid && (!st.hold_full || rx_ready)) begin
                next_st.hold_data = link.h2d_data;
                next_st.hold_full = 1'b1;
                next_st.hold_sof  = st.first;
                next_st.first     = 1'b0;
            end
            if (rx_done) begin
                next_st.rx_st   = uhsf_pkg::UHSF_RX_HUNT;
                next_st.rx_hist = '0;
            end
        end

        // transmit side
        case (st.tx_st)
            uhsf_pkg::UHSF_TX_IDLE: begin
                if (st.sleeping && wake_ask) begin
                    next_st.tx_st    = uhsf_pkg::UHSF_TX_WAKE; // [RULE_05]
                    next_st.wake_cnt = WAKE_LOAD;
                end else if (tx_valid) begin
                    next_st.tx_st  = uhsf_pkg::UHSF_TX_SYNC; // [RULE_06] [RULE_09]
                    next_st.tx_idx = '0;
                    next_st.cls    = tx_class; // [RULE_03]
                end
            end
            uhsf_pkg::UHSF_TX_WAKE: begin
                if (st.wake_cnt == '0) begin
                    next_st.sleeping = 1'b0;
                    next_st.tx_st    = uhsf_pkg::UHSF_TX_IDLE;
                end else begin
                    next_st.wake_cnt = st.wake_cnt - 1'b1;
                end
            end
            uhsf_pkg::UHSF_TX_SYNC: begin
                if (can_send) begin
                    next_st.out_data  = uhsf_pkg::SHORT_SYNC[31 - 8 * st.tx_idx[1:0] -: 8]; // [RULE_11]
                    next_st.out_valid = 1'b1;
                    next_st.tx_gap    = GAP_LOAD;
                    next_st.tx_idx    = st.tx_idx + 3'h1;
                    if (st.tx_idx == uhsf_pkg::SHORT_LEN - 3'h1) begin
                        next_st.tx_st = uhsf_pkg::UHSF_TX_BODY; // [RULE_06]
                    end
                end
            end
            uhsf_pkg::UHSF_TX_BODY: begin
                if (can_send && tx_valid) begin
                    next_st.out_data  = tx_data;
                    next_st.out_valid = 1'b1;
                    next_st.tx_gap    = GAP_LOAD;
                    if (tx_last) begin
                        next_st.tx_st    = uhsf_pkg::UHSF_TX_IDLE;
                        next_st.sleeping = sleep_req; // [RULE_08]
                    end
                end
            end
            default: begin
                next_st.tx_st = uhsf_pkg::UHSF_TX_IDLE;
            end
        endcase
        if (srst) begin
            next_st = '0;
            next_st.tx_st = uhsf_pkg::UHSF_TX_IDLE;
            next_st.rx_st = uhsf_pkg::UHSF_RX_HUNT;
            next_st.cls   = uhsf_pkg::UHSF_CPL;
        end
    end

    always_ff @(posedge clock) begin
        st <= next_st;
    end

    assign link.d2h_data  = st.out_data;
    assign link.d2h_valid = st.out_valid;
    // rts high while the hold is occupied or while waking from sleep
    assign link.dev_rts   = st.hold_full ||
                            (st.tx_st == uhsf_pkg::UHSF_TX_WAKE); // [RULE_05]
    assign tx_ready       = (st.tx_st == uhsf_pkg::UHSF_TX_BODY) && can_send; // [RULE_07]
    assign tx_busy        = (st.tx_st != uhsf_pkg::UHSF_TX_IDLE);
    assign tx_cur_class   = st.cls;
    assign rx_data        = st.hold_data;
    assign rx_valid       = st.hold_full;
    assign rx_sof         = st.hold_full && st.hold_sof;
    assign asleep         = st.sleeping;
endmodule
`default_nettype wire

/* core/uhsf_host.sv */
// Purpose: host end of the link, with its receive jitter buffer
// Assumes: user pulses mask and unmask around message handling
// Notes:   jitter buffer depth sets how early rts rises
`timescale 1ns/1ns
`default_nettype none
module uhsf_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = uhsf_pkg::JIT_DEPTH
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready,
    output logic [$clog2(DEPTH):0] level
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } uhsf_fifo_st_t;

    logic [WIDTH-1:0] mem [DEPTH];
    uhsf_fifo_st_t    st;
    uhsf_fifo_st_t    next_st;
    logic             push;
    logic             pop;

    assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data  = mem[st.rp];
    assign level     = st.cnt;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (srst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clock) begin
        st <= next_st;
        if (push) begin
            mem[st.wp] <= in_data;
        end
    end
endmodule

module uhsf_host #(
    parameter int unsigned BYTE_CYC = uhsf_pkg::BYTE_CYC
) (
    input  wire logic       clock,
    input  wire logic       srst,
    uhsf_if.host            link,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            tx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic            message_notify,
    input  wire logic       mask_message_notify,
    input  wire logic       unmask_message_notify,
    output logic            rx_overrun
);
    typedef struct packed {
        uhsf_pkg::uhsf_tx_t    tx_st;
        logic [2:0]            tx_idx;
        logic [uhsf_pkg::CNT_W-1:0] tx_gap;
        logic [7:0]            out_data;
        logic                  out_valid;
        uhsf_pkg::uhsf_rx_t    rx_st;
        logic [23:0]           rx_hist;
        logic                  masked;
        logic                  pending;
        logic                  notify;
        logic                  overrun;
    } uhsf_host_st_t;

    localparam logic [uhsf_pkg::CNT_W-1:0] GAP_LOAD =
        uhsf_pkg::CNT_W'(BYTE_CYC - 1);
    localparam int unsigned LW = $clog2(uhsf_pkg::JIT_DEPTH) + 1;

    uhsf_host_st_t st;
    uhsf_host_st_t next_st;
    logic          can_send;
    logic          jb_in_ready;
    logic          jb_valid;
    logic [7:0]    jb_data;
    logic          jb_pop;
    logic [LW-1:0] jb_level;
    logic          hit;

    uhsf_fifo #(.WIDTH(8), .DEPTH(uhsf_pkg::JIT_DEPTH)) u_jitter (
        .clock     (clock),
        .srst      (srst),
        .in_valid  (link.d2h_valid),
        .in_data   (link.d2h_data),
        .in_ready  (jb_in_ready),
        .out_valid (jb_valid),
        .out_data  (jb_data),
        .out_ready (jb_pop),
        .level     (jb_level)
    );

    assign can_send = (st.tx_gap == '0) && !link.dev_rts; // [RULE_15]
    assign jb_pop   = jb_valid && ((st.rx_st == uhsf_pkg::UHSF_RX_HUNT) || rx_ready);
    assign hit      = (st.rx_st == uhsf_pkg::UHSF_RX_HUNT) && jb_valid &&
                      uhsf_pkg::uhsf_match(st.rx_hist, jb_data, uhsf_pkg::SHORT_SYNC);

    always_comb begin
        next_st = st;
        next_st.out_valid = 1'b0;
        next_st.notify    = 1'b0;
        if (st.tx_gap != '0) begin
            next_st.tx_gap = st.tx_gap - 1'b1;
        end
        case (st.tx_st)
            uhsf_pkg::UHSF_TX_SYNC: begin
                if (can_send) begin
                    next_st.out_data  = uhsf_pkg::LONG_SYNC[63 - 8 * st.tx_idx -: 8]; // [RULE_10]
                    next_st.out_valid = 1'b1;
                    next_st.tx_gap    = GAP_LOAD;
                    next_st.tx_idx    = st.tx_idx + 3'h1;
                    if (st.tx_idx == 3'(uhsf_pkg::LONG_LEN - 4'h1)) begin
                        next_st.tx_st = uhsf_pkg::UHSF_TX_BODY; // [RULE_04]
                    end
                end
            end
            uhsf_pkg::UHSF_TX_BODY: begin
                if (can_send && tx_valid) begin
                    next_st.out_data  = tx_data;
                    next_st.out_valid = 1'b1;
                    next_st.tx_gap    = GAP_LOAD;
                    if (tx_last) begin
                        next_st.tx_st = uhsf_pkg::UHSF_TX_IDLE;
                    end
                end
            end
            default: begin
                if (tx_valid) begin
                    next_st.tx_st  = uhsf_pkg::UHSF_TX_SYNC; // [RULE_04] [RULE_13]
                    next_st.tx_idx = '0;
                end
            end
        endcase

        if (jb_pop) begin
            next_st.rx_hist = {st.rx_hist[15:0], jb_data};
        end
        if (link.d2h_valid && !jb_in_ready) begin
            next_st.overrun = 1'b1;
        end
        if (mask_message_notify) begin
            next_st.masked = 1'b1; // [RULE_02]
        end
        if (unmask_message_notify) begin
            next_st.masked  = 1'b0; // [RULE_02]
            next_st.rx_st   = uhsf_pkg::UHSF_RX_HUNT;
            next_st.rx_hist = '0;
            if (st.pending) begin
                // the waiting message stays open so its body can still be read
                next_st.notify  = 1'b1;
                next_st.pending = 1'b0;
                next_st.rx_st   = uhsf_pkg::UHSF_RX_MSG; // [RULE_01]
            end
        end
        // a match in the unmask cycle still notifies: set beats clear
        if (hit) begin
            next_st.rx_st = uhsf_pkg::UHSF_RX_MSG; // [RULE_01]
            if (st.masked && !unmask_message_notify) begin
                next_st.pending = 1'b1;
            end else begin
                next_st.notify = 1'b1; // [RULE_01]
            end
        end
        if (srst) begin
            next_st = '0;
            next_st.tx_st = uhsf_pkg::UHSF_TX_IDLE;
            next_st.rx_st = uhsf_pkg::UHSF_RX_HUNT;
        end
    end

    always_ff @(posedge clock) begin
        st <= next_st;
    end

    assign link.h2d_data  = st.out_data;
    assign link.h2d_valid = st.out_valid;
    // raise rts one word early, device may already be mid-decision
    assign link.host_rts  = (jb_level >= LW'(uhsf_pkg::JIT_DEPTH - 1)); // [RULE_07]
    assign tx_ready       = (st.tx_st == uhsf_pkg::UHSF_TX_BODY) && can_send;
    assign rx_data        = jb_data;
    assign rx_valid       = jb_valid && (st.rx_st == uhsf_pkg::UHSF_RX_MSG);
    assign message_notify = st.notify;
    assign rx_overrun     = st.overrun;
endmodule
`default_nettype wire

/* verif/uhsf_link_chk.sv */
// Purpose: concurrent checks on the link between the two framer ends
// Assumes: one clock domain, inputs are the link interface signals
// Notes:   pair checks key on sync bytes, so payloads must not reuse them
`timescale 1ns/1ns
`default_nettype none
module uhsf_link_chk #(
    parameter int unsigned BYTE_CYC = uhsf_pkg::BYTE_CYC
) (
    input wire logic       clock,
    input wire logic       srst,
    input wire logic [7:0] h2d_data,
    input wire logic       h2d_valid,
    input wire logic [7:0] d2h_data,
    input wire logic       d2h_valid,
    input wire logic       dev_rts,
    input wire logic       host_rts
);
    logic [15:0] h_gap;
    logic [15:0] d_gap;
    logic [7:0]  h_last;
    logic [7:0]  d_last;
    logic        h_seen;
    logic        d_seen;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // gaps saturate so a long idle never wraps into a false short gap
    always_ff @(posedge clock) begin
        if (srst) begin
            h_gap  <= 16'hffff;
            d_gap  <= 16'hffff;
            h_last <= 8'h00;
            d_last <= 8'h00;
            h_seen <= 1'b0;
            d_seen <= 1'b0;
        end else begin
            h_gap  <= h2d_valid ? 16'h0001 : h_gap + {15'h0000, h_gap != 16'hffff};
            d_gap  <= d2h_valid ? 16'h0001 : d_gap + {15'h0000, d_gap != 16'hffff};
            h_last <= h2d_valid ? h2d_data : h_last;
            d_last <= d2h_valid ? d2h_data : d_last;
            h_seen <= h_seen | h2d_valid;
            d_seen <= d_seen | d2h_valid;
        end
    end

    h2d_space_a: assert property (h2d_valid |-> h_gap >= BYTE_CYC)
        else $error("host bytes closer than one byte time");
    d2h_space_a: assert property (d2h_valid |-> d_gap >= BYTE_CYC)
        else $error("device bytes closer than one byte time");
    h2d_cts_a: assert property (h2d_valid |-> !$past(dev_rts))
        else $error("host sent while device asked to stop");
    d2h_pause_a: assert property (d2h_valid |-> !$past(host_rts))
        else $error("device sent while host asked to pause");
    long_start_a: assert property (h2d_valid && !h_seen |-> h2d_data == 8'h12)
        else $error("first host byte is not the long sync start");
    long_join_a: assert property (h2d_valid && h_last == 8'h21 |-> h2d_data == 8'hbb)
        else $error("long sync filler not followed by its tail");
    short_start_a: assert property (d2h_valid && !d_seen |-> d2h_data == 8'hab)
        else $error("first device byte is not the short sync start");
    short_order_a: assert property (d2h_valid && d_last == 8'hcd |-> d2h_data == 8'hdc)
        else $error("short sync bytes out of order");
endmodule
`default_nettype wire

/* verif/uart_host_sync_framing_tb.sv */
// Purpose: self-checking bench of device and host ends joined by the link
// Assumes: short byte time and wake time so the run stays brief
// Notes:   tx_data and tx_last are shared, only one end sends at a time
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
`define WAIT(c) for (t = 0; t < 3000 && !(c); t++) @(negedge clock); \
    if (t == 3000) miscompares++;
module uart_host_sync_framing_tb;
    localparam int unsigned BC = 8;
    localparam int unsigned WK = 8;
    logic                  clock;
    logic                  srst;
    logic [7:0]            tx_data;
    logic                  tx_last;
    logic                  h_tx_valid, h_tx_ready, h_rx_valid, h_rx_ready;
    logic                  notify, h_mask, h_unmask, overrun;
    logic [7:0]            h_rx_data, d_rx_data;
    logic                  d_tx_valid, d_tx_ready, d_busy, d_rx_valid, d_sof;
    logic                  d_rx_ready, d_rx_done, sleep_req, asleep, drx_sof;
    uhsf_pkg::uhsf_class_t d_class, d_cur;
    logic [7:0]            h2d_q[$], d2h_q[$], drx_q[$], hrx_q[$], pl[$];
    int                    miscompares, cmp_count, notify_cnt, wake_cnt, t, i;

    uhsf_if uhsf_if_i ();
    uhsf_dev #(.BYTE_CYC(BC), .WAKE_CYC(WK)) uhsf_dev_i (.clock(clock), .srst(srst),
        .link(uhsf_if_i), .tx_valid(d_tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_class(d_class), .tx_ready(d_tx_ready), .tx_busy(d_busy), .tx_cur_class(d_cur),
        .rx_data(d_rx_data), .rx_valid(d_rx_valid), .rx_sof(d_sof), .rx_ready(d_rx_ready),
        .rx_done(d_rx_done), .sleep_req(sleep_req), .asleep(asleep));
    uhsf_host #(.BYTE_CYC(BC)) uhsf_host_i (.clock(clock), .srst(srst), .link(uhsf_if_i),
        .tx_valid(h_tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(h_tx_ready),
        .rx_data(h_rx_data), .rx_valid(h_rx_valid), .rx_ready(h_rx_ready),
        .message_notify(notify), .mask_message_notify(h_mask),
        .unmask_message_notify(h_unmask), .rx_overrun(overrun));
    uhsf_link_chk #(.BYTE_CYC(BC)) uhsf_link_chk_i (.clock(clock), .srst(srst),
        .h2d_data(uhsf_if_i.h2d_data), .h2d_valid(uhsf_if_i.h2d_valid),
        .d2h_data(uhsf_if_i.d2h_data), .d2h_valid(uhsf_if_i.d2h_valid),
        .dev_rts(uhsf_if_i.dev_rts), .host_rts(uhsf_if_i.host_rts));

    always @(posedge clock) begin
        if (uhsf_if_i.h2d_valid === 1'b1) h2d_q.push_back(uhsf_if_i.h2d_data);
        if (uhsf_if_i.d2h_valid === 1'b1) d2h_q.push_back(uhsf_if_i.d2h_data);
        if (d_rx_valid === 1'b1 && d_rx_ready === 1'b1) begin
            if (drx_q.size() == 0) drx_sof = d_sof;
            drx_q.push_back(d_rx_data);
        end
        if (h_rx_valid === 1'b1 && h_rx_ready === 1'b1) hrx_q.push_back(h_rx_data);
        if (notify === 1'b1) notify_cnt++;
        if (asleep === 1'b1 && uhsf_if_i.dev_rts === 1'b1) wake_cnt++;
    end

    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // valid stays up between bytes; ready is looked at once settled
    task automatic send_msg(input bit dev, input logic [7:0] m[$]);
        int n;
        int w;
        for (n = 0; n < m.size(); n++) begin
            @(negedge clock);
            tx_data = m[n];
            tx_last = (n == m.size() - 1);
            if (dev) d_tx_valid = 1'b1;
            else h_tx_valid = 1'b1;
            for (w = 0; w < 3000 && (dev ? d_tx_ready : h_tx_ready) !== 1'b1; w++)
                @(negedge clock);
            if (w == 3000) miscompares++;
            @(posedge clock);
        end
        @(negedge clock);
        d_tx_valid = 1'b0;
        h_tx_valid = 1'b0;
        tx_last = 1'b0;
    endtask

    task automatic pulse(input int w);
        @(negedge clock);
        if (w == 0) h_mask = 1'b1;
        else if (w == 1) h_unmask = 1'b1;
        else d_rx_done = 1'b1;
        @(negedge clock);
        h_mask = 1'b0;
        h_unmask = 1'b0;
        d_rx_done = 1'b0;
    endtask

    task automatic chk_sync(input logic [7:0] q[$], input bit lng);
        for (int j = 0; j < (lng ? 8 : 4); j++)
            `CHK("sync", lng ? uhsf_pkg::LONG_SYNC[63-8*j -: 8]
                : uhsf_pkg::SHORT_SYNC[31-8*j -: 8], q[j])
    endtask

    task automatic chk_q(input logic [7:0] q[$], input logic [7:0] m[$]);
        `CHK("count", m.size(), q.size())
        foreach (m[j]) `CHK("byte", m[j], q[j])
    endtask

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        finish_test();
    end

    initial begin
        {srst, tx_last, h_tx_valid, d_tx_valid, h_rx_ready, d_rx_ready} = 6'h20;
        {h_mask, h_unmask, d_rx_done, sleep_req} = 4'h0;
        tx_data = 8'h00;
        d_class = uhsf_pkg::UHSF_CPL;
        {miscompares, cmp_count, notify_cnt, wake_cnt} = '0;
        repeat (8) @(negedge clock);
        srst = 1'b0;
        // first payload byte is held, so the host must stop after it
        pl = '{8'h5a, 8'h3c, 8'h7e};
        fork
            send_msg(1'b0, pl);
            begin
                `WAIT(d_rx_valid === 1'b1)
                repeat (4 * BC) @(negedge clock);
                `CHK("cts", 1'b1, uhsf_if_i.dev_rts)
                `CHK("held", 9, h2d_q.size())
                d_rx_ready = 1'b1;
            end
        join
        `WAIT(drx_q.size() == 3)
        chk_sync(h2d_q, 1'b1);
        chk_q(drx_q, pl);
        `CHK("sof", 1'b1, drx_sof)
        pulse(2);
        // an event found while masked notifies only at unmask, body still readable
        pulse(0);
        d_class = uhsf_pkg::UHSF_EVT;
        pl = '{8'h55};
        send_msg(1'b1, pl);
        repeat (2 * BC) @(negedge clock);
        `CHK("masked", 0, notify_cnt)
        pulse(1);
        @(negedge clock);
        `CHK("pending", 1, notify_cnt)
        h_rx_ready = 1'b1;
        `WAIT(hrx_q.size() == 1)
        h_rx_ready = 1'b0;
        `CHK("event", 8'h55, hrx_q[0])
        pulse(1);
        notify_cnt = 0;
        // every class from the device, host buffer stalls each one
        for (i = 0; i < 4; i++) begin
            d2h_q.delete();
            hrx_q.delete();
            pl = '{8'h30 + i[7:0], 8'h41, 8'h42, 8'h43};
            d_class = uhsf_pkg::uhsf_class_t'(i[1:0]);
            sleep_req = (i == 3);
            fork
                send_msg(1'b1, pl);
                begin
                    `WAIT(notify_cnt == i + 1)
                    pulse(0);
                    `WAIT(uhsf_if_i.host_rts === 1'b1)
                    repeat (3 * BC) @(negedge clock);
                    `CHK("paused", 7, d2h_q.size())
                    h_rx_ready = 1'b1;
                    `WAIT(hrx_q.size() == 4)
                    h_rx_ready = 1'b0;
                    pulse(1);
                end
            join
            `CHK("class", d_class, d_cur)
            chk_sync(d2h_q, 1'b0);
            chk_q(hrx_q, pl);
            `CHK("notify", i + 1, notify_cnt)
        end
        `CHK("asleep", 1'b1, asleep)
        sleep_req = 1'b0;
        // a new command wakes the device, which holds the host off meanwhile
        drx_q.delete();
        wake_cnt = 0;
        pl = '{8'h66, 8'h77};
        send_msg(1'b0, pl);
        `WAIT(drx_q.size() == 2)
        `CHK("woken", 1'b0, asleep)
        `CHK("wake", 1'b1, wake_cnt >= WK)
        chk_q(drx_q, pl);
        pulse(2);
        `CHK("overrun", 1'b0, overrun)
        `CHK("busy", 1'b0, d_busy)
        finish_test();
    end
endmodule
`default_nettype wire
